// ==== design/octdac_ctrl.sv ====
// serial control logic of the eight channel voltage output converter
// Summary of operation
// - strobe low lets serial clock shift data
// - strobe rising stops shifting, runs command
// - input bits sampled on serial clock rising
// - frames are 24 or 32 bits long
// - output echoes input 32 edges later
// - data output driven only while strobe low
// - update pin fall copies all inputs now
// - update fall during frame waits for strobe
// - update pin low powers channels up
// - power-down command ignored while update low
// - toggle fall loads A, rise loads B
// - toggles touch only toggle-selected channels
// - clear low forces strap code and span
// - clear also zeroes toggle select and mux, turns reference on
// - over-temperature flag pulls low when hot
// - flag stays low until strobe rises
// - three straps pick power-on span and code
// - grounded reference node starts reference off
// - monitor mux output off unless enabled
// - command, address, then data MSB first
// - long frame has eight leading don't-cares
// - update copies input and powers channel up
// - each channel has input registers A, B
`timescale 1ns/1ns
module octdac_ctrl
    import octdac_pkg::*;
(
    input  wire logic                         sys_clk,
    input  wire logic                         srst,
    input  wire logic                         serial_clk,
    input  wire logic                         sdi,
    input  wire logic                         select_load_n,
    output logic                              sdo_o,
    output logic                              sdo_oe,
    input  wire logic                         async_update_n,
    input  wire logic                         toggle_pin,
    input  wire logic                         async_clear_n,
    input  wire logic                         span_strap_0,
    input  wire logic                         span_strap_1,
    input  wire logic                         span_strap_2,
    input  wire logic                         ref_comp_grounded,
    input  wire logic                         overtemp_detect,
    output logic                              overtemp_flag_n_o,
    output logic                              overtemp_flag_n_oe,
    output logic [NCH-1:0][CODE_W-1:0]        dac_code,
    output logic [NCH-1:0][SPAN_W-1:0]        dac_span,
    output logic [NCH-1:0]                    chan_powered,
    output logic                              ref_enabled,
    output logic                              monitor_mux_en,
    output logic [MUX_SEL_W-1:0]              monitor_mux_sel
);

    // ---------------- link domain, serial clock ----------------
    logic [FRAME_W-1:0] shift_q;              // serial shift register
    logic               sdo_q;                // echo output flop

    // shift on rising serial clock only inside a frame
    always_ff @(posedge serial_clk) begin
        if (!select_load_n) begin
            shift_q <= {shift_q[FRAME_W-2:0], sdi};
        end
    end

    // oldest bit leaves on the following falling edge
    always_ff @(negedge serial_clk) begin
        sdo_q <= shift_q[FRAME_W-1];
    end

    assign sdo_o = sdo_q;

    // ---------------- system domain synchronisers ----------------
    logic [SYNC_W-1:0] pin_raw;               // raw asynchronous pins
    logic [SYNC_W-1:0] sync1_q;               // first stage, only for sync2
    logic [SYNC_W-1:0] sync2_q;               // second stage, safe to use
    logic [SYNC_W-1:0] sync3_q;               // delayed copy for edges

    assign pin_raw = {span_strap_2, span_strap_1, span_strap_0,
                      ref_comp_grounded, overtemp_detect, async_clear_n,
                      toggle_pin, async_update_n, select_load_n};

    // two flops on every pin before any logic sees it
    always_ff @(posedge sys_clk) begin
        sync1_q <= pin_raw;
        sync2_q <= sync1_q;
        sync3_q <= sync2_q;
    end

    logic              cs_high;               // strobe high, synchronised
    logic              cs_rise;               // strobe rising edge
    logic              upd_low;               // update pin held low
    logic              upd_fall;              // update pin falling edge
    logic              tgl_fall;              // toggle pin falling edge
    logic              tgl_rise;              // toggle pin rising edge
    logic              clr_act;               // clear pin held low
    logic [2:0]        strap;                 // span straps
    octdac_code_t      def_code;              // reset code from straps
    octdac_span_t      def_span;              // reset span from straps

    assign cs_high  = sync2_q[SY_CS];
    assign cs_rise  = sync2_q[SY_CS] & ~sync3_q[SY_CS];
    assign upd_low  = ~sync2_q[SY_UPD];
    assign upd_fall = ~sync2_q[SY_UPD] & sync3_q[SY_UPD];
    assign tgl_fall = ~sync2_q[SY_TGL] & sync3_q[SY_TGL];
    assign tgl_rise = sync2_q[SY_TGL] & ~sync3_q[SY_TGL];
    assign clr_act  = ~sync2_q[SY_CLR];
    assign strap    = sync2_q[SY_STRAP +: 3];
    assign def_span = strap;
    assign def_code = STRAP_MID_MASK[strap] ? CODE_MID : CODE_ZERO;

    // ---------------- power-on initialisation ----------------
    logic init_done_q;                        // straps caught after reset
    logic load_def;                           // load strap defaults now

    // catch the straps one cycle after reset release
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            init_done_q <= 1'b0;
        end else begin
            init_done_q <= 1'b1;
        end
    end

    assign load_def = srst | ~init_done_q | clr_act;

    // ---------------- frame capture ----------------
    logic [23:0] frame_q;                     // last 24 bits of a frame
    logic        exec_q;                      // one-cycle execute pulse

    // shift register is still once strobe is high, so sample it
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            frame_q <= 24'h000000;
            exec_q  <= 1'b0;
        end else begin
            exec_q <= cs_rise & ~clr_act;
            if (cs_rise) begin
                frame_q <= shift_q[23:0];
            end
        end
    end

    logic [CMD_W-1:0]  cmd;                   // command field
    logic [ADDR_W-1:0] addr;                  // channel address field
    octdac_code_t      data;                  // data word
    logic [NCH-1:0]    addr_oh;               // addressed channel

    assign cmd     = frame_q[CMD_LSB +: CMD_W];
    assign addr    = frame_q[ADDR_LSB +: ADDR_W];
    assign data    = frame_q[DATA_LSB +: CODE_W];
    assign addr_oh = addr[3] ? MASK_NONE : (MASK_NONE | (8'h01 << addr[2:0]));

    // ---------------- deferred update ----------------
    logic upd_pend_q;                         // update waiting for strobe
    logic upd_go;                             // update all channels now

    // a fall during a frame waits; a new fall wins over the execute pulse, clear wins over both
    always_ff @(posedge sys_clk) begin
        if (srst | clr_act) begin
            upd_pend_q <= 1'b0;
        end else if (upd_fall && !cs_high) begin
            upd_pend_q <= 1'b1;
        end else if (exec_q) begin
            upd_pend_q <= 1'b0;
        end
    end

    assign upd_go = (upd_fall & cs_high) | (upd_pend_q & exec_q);

    // ---------------- command decode ----------------
    logic [NCH-1:0] tgl_sel_q;                // toggle-select bits
    logic [NCH-1:0] wr_mask;                  // code write targets
    logic [NCH-1:0] span_mask;                // span write targets
    logic [NCH-1:0] upd_mask;                 // update targets
    logic [NCH-1:0] pd_mask;                  // power-down targets
    logic           pd_chip;                  // whole-chip power down
    logic           gtgl;                     // global toggle command

    // turn the executed command into per-channel masks
    always_comb begin
        wr_mask   = MASK_NONE;
        span_mask = MASK_NONE;
        upd_mask  = MASK_NONE;
        pd_mask   = MASK_NONE;
        pd_chip   = 1'b0;
        gtgl      = 1'b0;
        if (exec_q) begin
            unique case (cmd)
                CMD_WR_N:         wr_mask = addr_oh;
                CMD_WR_ALL:       wr_mask = MASK_ALL;
                CMD_SPAN_N:       span_mask = addr_oh;
                CMD_SPAN_ALL:     span_mask = MASK_ALL;
                CMD_UPD_N:        upd_mask = addr_oh;
                CMD_UPD_ALL:      upd_mask = MASK_ALL;
                CMD_WRUPD_N: begin
                    wr_mask  = addr_oh;
                    upd_mask = addr_oh;
                end
                CMD_WR_N_UPD_ALL: begin
                    wr_mask  = addr_oh;
                    upd_mask = MASK_ALL;
                end
                CMD_WRUPD_ALL: begin
                    wr_mask  = MASK_ALL;
                    upd_mask = MASK_ALL;
                end
                CMD_PD_N:         pd_mask = upd_low ? MASK_NONE : addr_oh;
                CMD_PD_CHIP: begin
                    pd_mask = upd_low ? MASK_NONE : MASK_ALL;
                    pd_chip = ~upd_low;
                end
                CMD_TGL_GLB:      gtgl = 1'b1;
                CMD_MUX, CMD_TGL_SEL, CMD_CONFIG, CMD_NOP: begin
                    // handled in the control registers or nothing to do
                end
            endcase
        end
        if (upd_go) begin
            upd_mask = MASK_ALL;
        end
    end

    // ---------------- input registers ----------------
    octdac_code_t [NCH-1:0] in_a_q;           // input register A
    octdac_code_t [NCH-1:0] in_b_q;           // input register B
    octdac_span_t [NCH-1:0] in_span_q;        // span input register
    octdac_code_t [NCH-1:0] in_a_d;           // A after this cycle's write
    octdac_span_t [NCH-1:0] in_span_d;        // span after this write

    // writes go to A unless the channel is toggle-selected, then to B
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            in_a_d[i]    = (wr_mask[i] && !tgl_sel_q[i]) ? data : in_a_q[i];
            in_span_d[i] = span_mask[i] ? data[SPAN_W-1:0] : in_span_q[i];
        end
    end

    // hold the input registers, defaults on reset and clear
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < NCH; i++) begin
            if (load_def) begin
                in_a_q[i]    <= def_code;
                in_b_q[i]    <= def_code;
                in_span_q[i] <= def_span;
            end else begin
                in_a_q[i]    <= in_a_d[i];
                in_span_q[i] <= in_span_d[i];
                if (wr_mask[i] && tgl_sel_q[i]) begin
                    in_b_q[i] <= data;
                end
            end
        end
    end

    // ---------------- DAC registers and power ----------------
    octdac_code_t [NCH-1:0] dac_code_q;       // live channel codes
    octdac_span_t [NCH-1:0] dac_span_q;       // live channel spans
    logic [NCH-1:0]         powered_q;        // channel powered state

    // update, toggle, and defaults; defaults win, then update over toggle
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < NCH; i++) begin
            if (load_def) begin
                dac_code_q[i] <= def_code;
                dac_span_q[i] <= def_span;
            end else if (upd_mask[i]) begin
                dac_code_q[i] <= in_a_d[i];
                dac_span_q[i] <= in_span_d[i];
            end else if (tgl_sel_q[i]) begin
                if (tgl_fall || (gtgl && !data[GTGL_B_BIT])) begin
                    dac_code_q[i] <= in_a_q[i];
                end else if (tgl_rise || gtgl) begin
                    dac_code_q[i] <= in_b_q[i];
                end
            end
        end
    end

    // power state: update or low update pin powers up
    always_ff @(posedge sys_clk) begin
        if (load_def) begin
            powered_q <= MASK_ALL;
        end else begin
            powered_q <= (powered_q & ~pd_mask) | upd_mask
                         | (upd_low ? MASK_ALL : MASK_NONE);
        end
    end

    // ---------------- control registers ----------------
    logic                 mux_en_q;           // monitor mux enabled
    logic [MUX_SEL_W-1:0] mux_sel_q;          // monitor mux source
    logic                 ref_en_q;           // internal reference on

    // toggle select and mux; clear zeroes them
    always_ff @(posedge sys_clk) begin
        if (load_def) begin
            tgl_sel_q <= MASK_NONE;
            mux_en_q  <= 1'b0;
            mux_sel_q <= 4'h0;
        end else if (exec_q) begin
            if (cmd == CMD_TGL_SEL) begin
                tgl_sel_q <= data[NCH-1:0];
            end
            if (cmd == CMD_MUX) begin
                mux_en_q  <= data[MUX_EN_BIT];
                mux_sel_q <= data[MUX_SEL_W-1:0];
            end
            if (pd_chip) begin
                mux_en_q <= 1'b0;
            end
        end
    end

    // reference: strap at power-on, config command afterward
    always_ff @(posedge sys_clk) begin
        if (srst || !init_done_q) begin
            ref_en_q <= ~sync2_q[SY_REF];
        end else if (clr_act) begin
            ref_en_q <= 1'b1;
        end else if (exec_q && cmd == CMD_CONFIG) begin
            ref_en_q <= ~data[CFG_REFDIS_BIT];
        end else if (pd_chip) begin
            ref_en_q <= 1'b0;
        end
    end

    // ---------------- over-temperature flag ----------------
    logic ot_q;                               // flag held low
    logic ot_low_q;                           // open-drain level, always low

    // new heat event wins over the strobe release
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ot_q     <= 1'b0;
            ot_low_q <= 1'b0;
        end else if (sync2_q[SY_OT]) begin
            ot_q <= 1'b1;
        end else if (cs_rise) begin
            ot_q <= 1'b0;
        end
    end

    // ---------------- data output enable ----------------
    logic sdo_oe_q;                           // drive echo output

    // drive the echo pin only while the strobe is low
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sdo_oe_q <= 1'b0;
        end else begin
            sdo_oe_q <= ~cs_high;
        end
    end

    assign sdo_oe             = sdo_oe_q;
    assign overtemp_flag_n_o  = ot_low_q;
    assign overtemp_flag_n_oe = ot_q;
    assign dac_code           = dac_code_q;
    assign dac_span           = dac_span_q;
    assign chan_powered       = powered_q;
    assign ref_enabled        = ref_en_q;
    assign monitor_mux_en     = mux_en_q;
    assign monitor_mux_sel    = mux_sel_q;

    // ---------------- checks ----------------
    default clocking dcb @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_sdo_hiz_high: assert property (cs_high |=> !sdo_oe_q)
        else $error("echo output driven while strobe high");
    a_sdo_drive_low: assert property (!cs_high |=> sdo_oe_q)
        else $error("echo output not driven during frame");
    a_exec_on_rise: assert property (cs_rise && !clr_act |=> exec_q)
        else $error("command not executed after strobe rise");
    a_update_deferred: assert property
        (upd_fall && !cs_high && !clr_act |=> upd_pend_q)
        else $error("update during frame not held");
    a_upd_low_power: assert property
        (upd_low && !clr_act && init_done_q |=> powered_q == MASK_ALL)
        else $error("channels not powered while update pin low");
    a_clear_ctrl_zero: assert property
        (clr_act |=> tgl_sel_q == MASK_NONE && !mux_en_q)
        else $error("clear left control registers set");
    a_ot_hold: assert property (ot_q && !cs_rise |=> ot_q)
        else $error("over-temperature flag released early");
    a_ot_release: assert property
        (ot_q && cs_rise && !sync2_q[SY_OT] |=> !ot_q)
        else $error("over-temperature flag not released");
    a_toggle_unsel: assert property
        ((tgl_rise || tgl_fall) && !tgl_sel_q[7]
         && !upd_mask[7] && !load_def |=> $stable(dac_code_q[7]))
        else $error("toggle changed an unselected channel");

endmodule : octdac_ctrl

// ==== design/octdac_pkg.sv ====
// constants and types for the octal converter serial control block
package octdac_pkg;

    // channel and word geometry
    localparam int NCH     = 8;       // number of converter channels
    localparam int CODE_W  = 16;      // code word width
    localparam int SPAN_W  = 3;       // span field width
    localparam int FRAME_W = 32;      // serial shift register length
    localparam int CMD_W   = 4;       // command field width
    localparam int ADDR_W  = 4;       // channel address field width

    // field positions inside the last 24 bits of a frame
    localparam int CMD_LSB  = 20;     // command field low bit
    localparam int ADDR_LSB = 16;     // channel address field low bit
    localparam int DATA_LSB = 0;      // data word low bit

    // data bit positions used by some commands
    localparam int MUX_EN_BIT     = 4;  // monitor mux enable
    localparam int MUX_SEL_W      = 4;  // monitor mux source select width
    localparam int CFG_REFDIS_BIT = 1;  // config: internal reference off
    localparam int GTGL_B_BIT     = 0;  // global toggle: 1 selects B

    // command codes
    localparam logic [3:0] CMD_WR_N         = 4'h0;
    localparam logic [3:0] CMD_UPD_N        = 4'h1;
    localparam logic [3:0] CMD_WR_N_UPD_ALL = 4'h2;
    localparam logic [3:0] CMD_WRUPD_N      = 4'h3;
    localparam logic [3:0] CMD_PD_N         = 4'h4;
    localparam logic [3:0] CMD_PD_CHIP      = 4'h5;
    localparam logic [3:0] CMD_SPAN_N       = 4'h6;
    localparam logic [3:0] CMD_CONFIG       = 4'h7;
    localparam logic [3:0] CMD_WR_ALL       = 4'h8;
    localparam logic [3:0] CMD_UPD_ALL      = 4'h9;
    localparam logic [3:0] CMD_WRUPD_ALL    = 4'hA;
    localparam logic [3:0] CMD_MUX          = 4'hB;
    localparam logic [3:0] CMD_TGL_SEL      = 4'hC;
    localparam logic [3:0] CMD_TGL_GLB      = 4'hD;
    localparam logic [3:0] CMD_SPAN_ALL     = 4'hE;
    localparam logic [3:0] CMD_NOP          = 4'hF;

    // reset values
    localparam logic [15:0] CODE_ZERO      = 16'h0000; // zero-scale code
    localparam logic [15:0] CODE_MID       = 16'h8000; // mid-scale code
    localparam logic [7:0]  STRAP_MID_MASK = 8'h1C;    // straps using mid
    localparam logic [7:0]  MASK_NONE      = 8'h00;    // no channel
    localparam logic [7:0]  MASK_ALL       = 8'hFF;    // every channel

    // bit order of the synchronised pin vector
    localparam int SY_CS    = 0;      // select/load strobe
    localparam int SY_UPD   = 1;      // asynchronous update pin
    localparam int SY_TGL   = 2;      // toggle pin
    localparam int SY_CLR   = 3;      // clear pin
    localparam int SY_OT    = 4;      // over-temperature detector
    localparam int SY_REF   = 5;      // reference node grounded strap
    localparam int SY_STRAP = 6;      // span straps, three bits
    localparam int SYNC_W   = 9;      // width of the vector

    typedef logic [CODE_W-1:0] octdac_code_t;   // one channel code
    typedef logic [SPAN_W-1:0] octdac_span_t;   // one channel span

endpackage : octdac_pkg

// ==== sim/octdac_host.sv ====
// host side model of the serial link that drives frames into the block
`timescale 1ns/1ns
module octdac_host (
    output logic        serial_clk,
    output logic        sdi,
    output logic        select_load_n,
    input  wire logic   sdo
);
    logic [31:0] echo_q; // echo bits gathered during the last frame

    // idle: link clock stands still, strobe high
    initial begin
        serial_clk    = 1'b0;
        sdi           = 1'b0;
        select_load_n = 1'b1;
        echo_q        = 32'h0;
    end

    // one frame of n bits, msb first, 12 ns link clock
    task automatic frame(input logic [31:0] w, input int n);
        // start off the system clock edges, link phase is unrelated
        #1 select_load_n = 1'b0;
        // output enable follows the strobe through synchronisers
        #20;
        for (int i = n - 1; i >= 0; i--) begin
            sdi = w[i];
            #6 serial_clk = 1'b1;
            // echo bit was launched on the previous falling edge
            echo_q = {echo_q[30:0], sdo};
            #6 serial_clk = 1'b0;
        end
        #6 select_load_n = 1'b1;
        sdi = ~sdi; // stale data bit is not left on the line
        #30;
    endtask : frame
endmodule : octdac_host

// ==== sim/tb.sv ====
// self-checking bench for the octal converter serial control block
`timescale 1ns/1ns
module tb;
    import octdac_pkg::*;
    logic                      sys_clk, srst, serial_clk, sdi, select_load_n;
    logic                      sdo_o, sdo_oe, sdo_line, async_update_n;
    logic                      toggle_pin, async_clear_n, overtemp_detect;
    logic                      flag_o, flag_oe, ref_enabled, monitor_mux_en;
    logic [NCH-1:0][CODE_W-1:0] dac_code;
    logic [NCH-1:0][SPAN_W-1:0] dac_span;
    logic [NCH-1:0]            chan_powered;
    logic [MUX_SEL_W-1:0]      monitor_mux_sel;
    int                        fails, tests_run;
    logic [2:0]                strap;
    logic                      ref_gnd;

    assign sdo_line = sdo_oe ? sdo_o : 1'b1; // echo line has a pull-up

    octdac_host host (.serial_clk(serial_clk), .sdi(sdi),
        .select_load_n(select_load_n), .sdo(sdo_line));

    octdac_ctrl DUT (.sys_clk(sys_clk), .srst(srst), .serial_clk(serial_clk),
        .sdi(sdi), .select_load_n(select_load_n), .sdo_o(sdo_o),
        .sdo_oe(sdo_oe), .async_update_n(async_update_n),
        .toggle_pin(toggle_pin), .async_clear_n(async_clear_n),
        .span_strap_0(strap[0]), .span_strap_1(strap[1]),
        .span_strap_2(strap[2]),
        .ref_comp_grounded(ref_gnd), .overtemp_detect(overtemp_detect),
        .overtemp_flag_n_o(flag_o), .overtemp_flag_n_oe(flag_oe),
        .dac_code(dac_code), .dac_span(dac_span),
        .chan_powered(chan_powered), .ref_enabled(ref_enabled),
        .monitor_mux_en(monitor_mux_en), .monitor_mux_sel(monitor_mux_sel));

    // 250 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // wait n falling edges of the system clock
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc

    // one frame with a don't-care lead byte, then let it execute
    task automatic fr(input logic [3:0] c, input logic [3:0] a,
                      input logic [15:0] d, input int n);
        host.frame({8'hA5, c, a, d}, n);
        cyc(10);
    endtask : fr

    // print counts and verdict, then stop
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    // watchdog: whole sequence takes about 12.5 us
    initial begin
        #60000;
        fails++;
        complete_run();
    end

    // test sequence
    initial begin
        fails = 0;
        tests_run = 0;
        srst = 1'b1;
        async_update_n = 1'b1;
        toggle_pin = 1'b1;
        async_clear_n = 1'b1;
        overtemp_detect = 1'b0;
        strap = 3'b010;
        ref_gnd = 1'b0;
        cyc(3);
        srst <= 1'b0;
        cyc(6);
        check(dac_code[0], CODE_MID);
        check(dac_span[7], 3'd2);
        check(ref_enabled, 1'b1);
        $display("done: power-on defaults");
        fr(CMD_WRUPD_N, 4'h1, 16'h1234, 24);
        check(dac_code[1], 16'h1234);
        fr(CMD_WRUPD_N, 4'h2, 16'hABCD, 32);
        check(dac_code[2], 16'hABCD);
        check(sdo_oe, 1'b0);
        fr(CMD_NOP, 4'h0, 16'h0000, 32);
        check(host.echo_q, {8'hA5, CMD_WRUPD_N, 8'h2A, 12'hBCD});
        $display("done: frames and echo");
        fr(CMD_WR_N, 4'h3, 16'h5555, 24);
        check(dac_code[3], CODE_MID);
        async_update_n <= 1'b0;
        cyc(8);
        check(dac_code[3], 16'h5555);
        fr(CMD_PD_N, 4'h5, 16'h0000, 24);
        check(chan_powered[5], 1'b1);
        async_update_n <= 1'b1;
        fr(CMD_PD_N, 4'h4, 16'h0000, 24);
        check(chan_powered[4], 1'b0);
        async_update_n <= 1'b0;
        cyc(8);
        check(chan_powered[4], 1'b1);
        async_update_n <= 1'b1;
        fr(CMD_WR_N, 4'h0, 16'h2222, 24);
        // update pin falls in mid-frame: must wait for the strobe
        fork
            host.frame(32'h00F00000, 32);
            begin
                cyc(40);
                async_update_n <= 1'b0;
                cyc(10);
                check(dac_code[0], CODE_MID);
                check(sdo_oe, 1'b1);
            end
        join
        cyc(10);
        check(dac_code[0], 16'h2222);
        async_update_n <= 1'b1;
        $display("done: update pin");
        fr(CMD_WR_N, 4'h6, 16'h1111, 24);
        fr(CMD_WR_N, 4'h7, 16'h3333, 24);
        fr(CMD_TGL_SEL, 4'h0, 16'h0040, 24);
        fr(CMD_WR_N, 4'h6, 16'h7777, 24);
        toggle_pin <= 1'b0;
        cyc(8);
        check(dac_code[6], 16'h1111);
        check(dac_code[7], CODE_MID);
        toggle_pin <= 1'b1;
        cyc(8);
        check(dac_code[6], 16'h7777);
        $display("done: toggle");
        fr(CMD_MUX, 4'h0, 16'h0013, 24);
        check({monitor_mux_en, monitor_mux_sel}, 5'h13);
        overtemp_detect <= 1'b1;
        cyc(6);
        check({flag_oe, flag_o}, 2'b10);
        overtemp_detect <= 1'b0;
        cyc(6);
        check(flag_oe, 1'b1);
        fr(CMD_NOP, 4'h0, 16'h0000, 24);
        check(flag_oe, 1'b0);
        $display("done: mux and flag");
        async_clear_n <= 1'b0;
        cyc(6);
        check(dac_code[1], CODE_MID);
        check(monitor_mux_en, 1'b0);
        async_clear_n <= 1'b1;
        cyc(4);
        fr(CMD_WRUPD_N, 4'h6, 16'h6666, 24);
        check(dac_code[6], 16'h6666);
        $display("done: clear");
        fr(CMD_SPAN_N, 4'h3, 16'h0004, 24);
        fr(CMD_UPD_N, 4'h3, 16'h0000, 24);
        check(dac_span[3], 3'd4);
        fr(CMD_SPAN_ALL, 4'h0, 16'h0001, 24);
        fr(CMD_WR_ALL, 4'h0, 16'h4444, 24);
        check(dac_code[5], CODE_MID);
        fr(CMD_UPD_ALL, 4'h0, 16'h0000, 24);
        check(dac_code[5], 16'h4444);
        check(dac_span[0], 3'd1);
        fr(CMD_WR_N_UPD_ALL, 4'h1, 16'h0101, 24);
        check(dac_code[1], 16'h0101);
        fr(CMD_WRUPD_ALL, 4'h0, 16'h0202, 24);
        check(dac_code[7], 16'h0202);
        fr(CMD_TGL_SEL, 4'h0, 16'h0001, 24);
        fr(CMD_WR_N, 4'h0, 16'h0303, 24);
        fr(CMD_TGL_GLB, 4'h0, 16'h0001, 24);
        check(dac_code[0], 16'h0303);
        fr(CMD_TGL_GLB, 4'h0, 16'h0000, 24);
        check(dac_code[0], 16'h0202);
        check(dac_code[1], 16'h0202);
        fr(CMD_CONFIG, 4'h0, 16'h0002, 24);
        check(ref_enabled, 1'b0);
        fr(CMD_MUX, 4'h0, 16'h0011, 24);
        fr(CMD_PD_CHIP, 4'h0, 16'h0000, 24);
        check({chan_powered, monitor_mux_en}, 9'h000);
        fr(CMD_UPD_N, 4'h2, 16'h0000, 24);
        check(chan_powered, 8'h04);
        fr(CMD_CONFIG, 4'h0, 16'h0000, 24);
        check(ref_enabled, 1'b1);
        $display("done: command set");
        strap <= 3'b101;
        ref_gnd <= 1'b1;
        srst <= 1'b1;
        cyc(3);
        srst <= 1'b0;
        cyc(6);
        check(dac_code[4], CODE_ZERO);
        check(dac_span[6], 3'd5);
        check(ref_enabled, 1'b0);
        $display("done: strap reset");
        complete_run();
    end
endmodule : tb
